// ---- sysbus_ctl_defines.vh ----
// Register offsets, field positions, reset values and timing counts for the bus control block
`ifndef SYSBUS_CTL_DEFINES_VH
`define SYSBUS_CTL_DEFINES_VH

`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_STAT      8'h08
`define REG_IRQ_MASK      8'h0c
`define REG_BRKPT         8'h10
`define REG_STRAP         8'h14

`define CTRL_FAULT_MODE_LSB 0
`define CTRL_REINIT_REQ     2
`define CTRL_STALL_REQ      3
`define CTRL_ISSUE_REQ      4
`define CTRL_LOCKED         5
`define CTRL_RESET_VAL      32'h0000_0000

`define FAULT_MODE_OFF      2'h0
`define FAULT_MODE_INTERNAL_FAULT_N     2'h1
`define FAULT_MODE_REQ      2'h2
`define FAULT_MODE_ANY      2'h3

`define IRQ_REINIT_SEEN     0
`define IRQ_FAULT_SENT      1
`define IRQ_PRIO_SEEN       2
`define IRQ_STALL_SEEN      3
`define IRQ_WIDTH           4

`define STRAP_DRV_BIT       0
`define STRAP_OBS_BIT       1

`define FAULT_PULSE_CYC     2'h1
`define STALL_PHASE_LEN     2'h2

`endif

// ---- sysbus_error_stall_priority.v ----
// Bus error, reinit, stall and priority control with AXI4-Lite registers
// How it works
// - Incoming bus fault is never observed
// - Fault drive mode: off, internal_fault_n, requester, any
// - Drive reinit on unreliable bus when enabled
// - Observed reinit resets bus machines, drops data
// - Reinit restores arbitration id, clears counts
// - Caches untouched by reinit
// - Unable to accept: assert stall signal
// - No new transaction while stall seen
// - Stall driven and sampled on phase edges
// - Priority request blocks unlocked new requests
// - Two-bit breakpoint status outputs
// - Two-bit breakpoint/perfmon status outputs
// - All pins driven and sampled on rising edge
// - Straps captured from address at reset release
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sysbus_ctl_defines.vh"

module sysbus_error_stall_priority #(
    parameter ID_RESET = 2'h0
) (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [32:0] addr_strap_in,
    input  wire        bus_fault_n_in,
    output reg         bus_fault_n_out,
    output reg         bus_fault_n_oe,
    input  wire        bus_reinit_n_in,
    output reg         bus_reinit_n_out,
    output reg         bus_reinit_n_oe,
    input  wire        stall_next_req_n_in,
    output reg         stall_next_req_n_out,
    output reg         stall_next_req_n_oe,
    input  wire        priority_agent_req_n,
    output reg  [1:0]  brkpt_status_n,
    output reg  [1:0]  brkpt_perfmon_status_n,
    input  wire        internal_fault,
    input  wire        req_fault_seen,
    input  wire        any_fault_seen,
    input  wire        bus_unreliable,
    input  wire        rx_full,
    input  wire        issue_req,
    input  wire        issue_locked,
    output wire        issue_grant,
    output reg         internal_fault_n,
    input  wire [1:0]  brkpt_hit,
    input  wire [1:0]  perfmon_ovf,
    output reg  [1:0]  arb_id_r,
    output reg  [7:0]  inflight_cnt_r,
    output wire        irq
);

    reg                  reset_d_r;
    reg                  strap_drv_r;
    reg                  strap_obs_r;
    reg  [31:0]          ctrl_r;
    reg  [`IRQ_WIDTH-1:0] irq_stat_r;
    reg  [`IRQ_WIDTH-1:0] irq_mask_r;
    reg  [1:0]           phase_r;
    reg                  stall_seen_r;
    reg                  prio_seen_r;
    reg                  reinit_seen_r;
    reg                  aw_held_r;
    reg  [7:0]           aw_addr_r;
    reg                  w_held_r;
    reg  [31:0]          w_data_r;
    reg  [3:0]           w_strb_r;
    reg                  fault_evt;
    reg  [`IRQ_WIDTH-1:0] evt;
    wire [1:0]           fault_mode;
    wire                 wr_go;
    wire                 rd_go;
    wire                 reinit_obs;
    wire                 sample_edge;
    wire [31:0]          wmask;

    assign fault_mode = ctrl_r[`CTRL_FAULT_MODE_LSB+1:`CTRL_FAULT_MODE_LSB];
    // Phase 0 is the only drive/sample edge, so agents never toggle together
    assign sample_edge = (phase_r == 2'h0);
    assign reinit_obs = strap_obs_r && !bus_reinit_n_in;

    // Strap capture one edge after release; async reset only loads constants
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reset_d_r   <= 1'b1;
            strap_drv_r <= 1'b0;
            strap_obs_r <= 1'b0;
        end else begin
            reset_d_r <= 1'b0;
            if (reset_d_r) begin
                strap_drv_r <= addr_strap_in[`STRAP_DRV_BIT];
                strap_obs_r <= addr_strap_in[`STRAP_OBS_BIT];
            end
        end
    end
    // Straps stay fixed until the next reset

    // Phase divider for stall signalling
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phase_r <= 2'h0;
        end else if (reinit_obs || phase_r == `STALL_PHASE_LEN - 2'h1) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // Pin sampling on rising edge; bus fault input is deliberately unread
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stall_seen_r  <= 1'b0;
            prio_seen_r   <= 1'b0;
            reinit_seen_r <= 1'b0;
        end else begin
            if (reinit_obs) begin
                stall_seen_r <= 1'b0;
            end else if (sample_edge) begin
                stall_seen_r <= !stall_next_req_n_in;
            end
            prio_seen_r   <= !priority_agent_req_n;
            reinit_seen_r <= reinit_obs;
        end
    end

    // Stalled or priority-owned bus blocks issue; locked sequences continue past priority only
    assign issue_grant = issue_req && !stall_seen_r && !reinit_obs
                         && (!prio_seen_r || issue_locked);

    // Arbitration id and in-flight count; caches are outside and untouched
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            arb_id_r       <= ID_RESET;
            inflight_cnt_r <= 8'h00;
        end else if (reinit_obs) begin
            arb_id_r       <= ID_RESET;
            inflight_cnt_r <= 8'h00;
        end else if (issue_grant) begin
            arb_id_r       <= arb_id_r + 2'h1;
            inflight_cnt_r <= inflight_cnt_r + 8'h01;
        end
    end

    always @* begin
        case (fault_mode)
            `FAULT_MODE_INTERNAL_FAULT_N: fault_evt = internal_fault;
            `FAULT_MODE_REQ:  fault_evt = req_fault_seen;
            `FAULT_MODE_ANY:  fault_evt = any_fault_seen;
            default:          fault_evt = 1'b0;
        endcase
    end

    // Pin drivers, all registered on the rising edge
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bus_fault_n_out        <= 1'b1;
            bus_fault_n_oe         <= 1'b0;
            bus_reinit_n_out       <= 1'b1;
            bus_reinit_n_oe        <= 1'b0;
            stall_next_req_n_out   <= 1'b1;
            stall_next_req_n_oe    <= 1'b0;
            internal_fault_n       <= 1'b1;
            brkpt_status_n         <= 2'h3;
            brkpt_perfmon_status_n <= 2'h3;
        end else begin
            bus_fault_n_out  <= 1'b0;
            bus_fault_n_oe   <= fault_evt;
            internal_fault_n <= !internal_fault;
            bus_reinit_n_out <= 1'b0;
            bus_reinit_n_oe  <= strap_drv_r
                                && (bus_unreliable || ctrl_r[`CTRL_REINIT_REQ]);
            // Open drain: drive low or release, only on the phase edge
            if (sample_edge) begin
                stall_next_req_n_out <= 1'b0;
                stall_next_req_n_oe  <= rx_full || ctrl_r[`CTRL_STALL_REQ];
            end
            brkpt_status_n         <= ~brkpt_hit;
            brkpt_perfmon_status_n <= ~(brkpt_hit | perfmon_ovf);
        end
    end

    // Interrupt events
    always @* begin
        evt = {`IRQ_WIDTH{1'b0}};
        evt[`IRQ_REINIT_SEEN] = reinit_obs;
        evt[`IRQ_FAULT_SENT]  = fault_evt;
        evt[`IRQ_PRIO_SEEN]   = !priority_agent_req_n && !prio_seen_r;
        evt[`IRQ_STALL_SEEN]  = sample_edge && !stall_next_req_n_in && !stall_seen_r;
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // AXI4-Lite slave: address and data taken in either order
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && !s_axi_rvalid;
    assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_held_r    <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_held_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            ctrl_r       <= `CTRL_RESET_VAL;
            irq_mask_r   <= {`IRQ_WIDTH{1'b0}};
            irq_stat_r   <= {`IRQ_WIDTH{1'b0}};
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Set wins over write-one-to-clear
            irq_stat_r <= irq_stat_r | evt;
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                if (aw_addr_r[7:2] == `REG_CTRL >> 2) begin
                    ctrl_r <= (ctrl_r & ~wmask) | (w_data_r & wmask);
                end else if (aw_addr_r[7:2] == `REG_IRQ_STAT >> 2) begin
                    irq_stat_r <= (irq_stat_r & ~(w_data_r[`IRQ_WIDTH-1:0]
                                  & wmask[`IRQ_WIDTH-1:0])) | evt;
                end else if (aw_addr_r[7:2] == `REG_IRQ_MASK >> 2) begin
                    irq_mask_r <= (irq_mask_r & ~wmask[`IRQ_WIDTH-1:0])
                                  | (w_data_r[`IRQ_WIDTH-1:0] & wmask[`IRQ_WIDTH-1:0]);
                end else if (aw_addr_r[7:2] == `REG_STATUS >> 2
                             || aw_addr_r[7:2] == `REG_BRKPT >> 2
                             || aw_addr_r[7:2] == `REG_STRAP >> 2) begin
                    s_axi_bresp <= 2'h0;
                end else begin
                    s_axi_bresp <= 2'h2;
                end
            end
        end
    end

    // Read channel, one cycle answer
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr[7:2] == `REG_CTRL >> 2) begin
                s_axi_rdata <= ctrl_r;
            end else if (s_axi_araddr[7:2] == `REG_STATUS >> 2) begin
                s_axi_rdata <= {14'h0000, arb_id_r, inflight_cnt_r, 4'h0,
                                reinit_seen_r, prio_seen_r, stall_seen_r, !issue_grant};
            end else if (s_axi_araddr[7:2] == `REG_IRQ_STAT >> 2) begin
                s_axi_rdata <= {28'h000_0000, irq_stat_r};
            end else if (s_axi_araddr[7:2] == `REG_IRQ_MASK >> 2) begin
                s_axi_rdata <= {28'h000_0000, irq_mask_r};
            end else if (s_axi_araddr[7:2] == `REG_BRKPT >> 2) begin
                s_axi_rdata <= {28'h000_0000, ~brkpt_perfmon_status_n, ~brkpt_status_n};
            end else if (s_axi_araddr[7:2] == `REG_STRAP >> 2) begin
                s_axi_rdata <= {30'h0000_0000, strap_obs_r, strap_drv_r};
            end else begin
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // sysbus_error_stall_priority
`default_nettype wire

// ---- esp_checker.sv ----
// Pin-level checks for the bus error, stall and priority block
`timescale 1ns/1ps
`default_nettype none
module esp_checker #(
    parameter logic [1:0] ID_RESET = 2'h0
) (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic [32:0] addr_strap_in,
    input wire logic        bus_reinit_n_in,
    input wire logic        bus_reinit_n_oe,
    input wire logic        stall_next_req_n_in,
    input wire logic        stall_next_req_n_oe,
    input wire logic        priority_agent_req_n,
    input wire logic [1:0]  brkpt_status_n,
    input wire logic [1:0]  brkpt_perfmon_status_n,
    input wire logic [1:0]  brkpt_hit,
    input wire logic [1:0]  perfmon_ovf,
    input wire logic        bus_unreliable,
    input wire logic        rx_full,
    input wire logic        issue_locked,
    input wire logic        issue_grant,
    input wire logic [1:0]  arb_id_r,
    input wire logic [7:0]  inflight_cnt_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    brk_status_a: assert property (brkpt_status_n == ~$past(brkpt_hit))
        else $error("breakpoint status lost");
    perf_status_a: assert property (
        brkpt_perfmon_status_n == ~$past(brkpt_hit | perfmon_ovf)) else $error("perfmon status lost");
    reinit_drive_a: assert property (
        $rose(bus_unreliable) && addr_strap_in[0] |-> ##[1:2] bus_reinit_n_oe) else $error("no reinit");
    reinit_clear_a: assert property (!bus_reinit_n_in && addr_strap_in[1] |=>
        arb_id_r == ID_RESET && inflight_cnt_r == 8'h00) else $error("reinit left state");
    stall_phase_a: assert property (
        $changed(stall_next_req_n_oe) |=> $stable(stall_next_req_n_oe)) else $error("stall off phase");
    stall_drive_a: assert property (rx_full[*5] |-> stall_next_req_n_oe)
        else $error("full but no stall");
    stall_block_a: assert property ((!stall_next_req_n_in)[*5] |-> !issue_grant)
        else $error("grant during stall");
    prio_block_a: assert property (!issue_locked && $past(!priority_agent_req_n) &&
        $past(!priority_agent_req_n, 2) |-> !issue_grant) else $error("grant under priority");
endmodule // esp_checker
bind sysbus_error_stall_priority esp_checker #(.ID_RESET(ID_RESET)) chk (.*);
`default_nettype wire

// ---- far_agents.sv ----
// Far side of the bus: central agent, priority agent, second agent
`timescale 1ns/1ps
`default_nettype none
module far_agents (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       bus_fault_n_oe,
    input  wire logic       bus_reinit_n_oe,
    input  wire logic       stall_next_req_n_oe,
    input  wire logic       fault_go,
    input  wire logic       reinit_go,
    input  wire logic       stall_go,
    input  wire logic [3:0] prio_jobs,
    output logic            bus_fault_n_in,
    output logic            bus_reinit_n_in,
    output logic            stall_next_req_n_in,
    output logic            priority_agent_req_n
);
    logic [3:0] left_r;
    logic       ph_r;
    logic       stall_r;
    // Pulled-up wired lines, low while any agent drives
    assign bus_fault_n_in = ~(bus_fault_n_oe | fault_go);
    assign bus_reinit_n_in = ~(bus_reinit_n_oe | reinit_go);
    assign stall_next_req_n_in = ~(stall_next_req_n_oe | stall_r);
    assign priority_agent_req_n = (left_r == 4'h0);
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            left_r <= 4'h0;
            ph_r <= 1'b0;
            stall_r <= 1'b0;
        end else begin
            ph_r <= ~ph_r;
            if (ph_r) begin
                stall_r <= stall_go;
            end
            // Held low until the last own job retires
            left_r <= (left_r != 4'h0) ? left_r - 4'h1 : prio_jobs;
        end
    end
endmodule // far_agents
`default_nettype wire

// ---- tb_sysbus_error_stall_priority.sv ----
// Self-checking bench for the bus error, stall and priority block
`timescale 1ns/1ps
`default_nettype none
`include "sysbus_ctl_defines.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_sysbus_error_stall_priority;
    localparam logic [1:0] ID_R = 2'h1;
    logic clk_sys = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, internal_fault = 0, req_fault_seen = 0;
    logic any_fault_seen = 0, bus_unreliable = 0, rx_full = 0, issue_req = 0, issue_locked = 0;
    logic fault_go = 0, reinit_go = 0, stall_go = 0;
    logic [3:0]  prio_jobs = 0, s_axi_wstrb = 4'hf;
    logic [1:0]  brkpt_hit = 0, perfmon_ovf = 0, s_axi_bresp, s_axi_rresp, arb_id_r;
    logic [1:0]  brkpt_status_n, brkpt_perfmon_status_n;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, inflight_cnt_r;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [32:0] addr_strap_in = 33'h3;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic bus_fault_n_in, bus_fault_n_out, bus_fault_n_oe, bus_reinit_n_in, bus_reinit_n_out;
    logic bus_reinit_n_oe, stall_next_req_n_in, stall_next_req_n_out, stall_next_req_n_oe;
    logic priority_agent_req_n, issue_grant, internal_fault_n;
    int n_mismatch = 0, samples_checked = 0;
    sysbus_error_stall_priority #(.ID_RESET(ID_R)) dut (.*);
    far_agents agents (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge clk_sys);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk_sys);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        `CHK({bus_fault_n_oe, brkpt_status_n, arb_id_r}, {1'b0, 2'h3, ID_R})
        `CHK({bus_fault_n_out, bus_reinit_n_out, stall_next_req_n_out}, 3'h0)
        rd(`REG_STRAP, d, r);
        `CHK({r, d[1:0]}, 4'h3)
        wr(`REG_STRAP, 32'h0, 2'h0);
        rd(`REG_STRAP, d, r);
        `CHK(d[1:0], 2'h3)
        rd(8'h40, d, r);
        `CHK(r, 2'h2)
        wr(8'h40, 32'h0, 2'h2);
        $display("t_regs done");
    endtask
    task automatic t_brkpt;
        @(posedge clk_sys);
        brkpt_hit <= 2'h1;
        perfmon_ovf <= 2'h2;
        internal_fault <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 `CHK(internal_fault_n, 1'b0)
        `CHK(brkpt_status_n, 2'h2)
        `CHK(brkpt_perfmon_status_n, 2'h0)
        @(posedge clk_sys);
        internal_fault <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 `CHK(internal_fault_n, 1'b1)
        $display("t_brkpt done");
    endtask
    task automatic t_fault;
        logic seen;
        logic a;
        logic [31:0] d;
        logic [1:0] r;
        for (int m = 0; m < 4; m++) begin
            wr(`REG_CTRL, 32'(m), 2'h0);
            for (int s = 1; s < 4; s++) begin
                seen = 1'b0;
                @(posedge clk_sys);
                {any_fault_seen, req_fault_seen, internal_fault} <= 3'(1 << (s - 1));
                fault_go <= 1'b1;
                repeat (4) begin
                    @(posedge clk_sys);
                    seen |= bus_fault_n_oe;
                end
                {any_fault_seen, req_fault_seen, internal_fault} <= 3'h0;
                fault_go <= 1'b0;
                repeat (4) @(posedge clk_sys);
                `CHK(seen, m == s)
            end
        end
        // A set mask bit lets its status bit through
        wr(`REG_IRQ_MASK, 32'h0, 2'h0);
        #1 a = irq;
        wr(`REG_IRQ_MASK, 32'hf, 2'h0);
        #1 `CHK({a, irq}, 2'h1)
        rd(`REG_IRQ_STAT, d, r);
        `CHK(d[`IRQ_FAULT_SENT], 1'b1)
        wr(`REG_IRQ_STAT, 32'hf, 2'h0);
        #1 `CHK(irq, 1'b0)
        $display("t_fault done");
    endtask
    task automatic t_stall;
        @(posedge clk_sys);
        issue_req <= 1'b1;
        rx_full <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 `CHK({stall_next_req_n_in, issue_grant}, 2'h0)
        rx_full <= 1'b0;
        stall_go <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 `CHK(issue_grant, 1'b0)
        stall_go <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 `CHK(issue_grant, 1'b1)
        $display("t_stall done");
    endtask
    task automatic t_prio;
        @(posedge clk_sys);
        prio_jobs <= 4'h8;
        @(posedge clk_sys);
        prio_jobs <= 4'h0;
        repeat (3) @(posedge clk_sys);
        #1 `CHK(issue_grant, 1'b0)
        issue_locked <= 1'b1;
        @(posedge clk_sys);
        #1 `CHK(issue_grant, 1'b1)
        issue_locked <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 `CHK({priority_agent_req_n, issue_grant}, 2'h3)
        $display("t_prio done");
    endtask
    task automatic t_reinit;
        @(posedge clk_sys);
        issue_req <= 1'b0;
        reinit_go <= 1'b1;
        @(posedge clk_sys);
        reinit_go <= 1'b0;
        issue_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        issue_req <= 1'b0;
        #1 `CHK({arb_id_r, inflight_cnt_r}, {ID_R + 2'h2, 8'h02})
        reinit_go <= 1'b1;
        @(posedge clk_sys);
        reinit_go <= 1'b0;
        #1 `CHK({arb_id_r, inflight_cnt_r}, {ID_R, 8'h00})
        bus_unreliable <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 `CHK({bus_reinit_n_oe, bus_reinit_n_in}, 2'h2)
        bus_unreliable <= 1'b0;
        $display("t_reinit done");
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_regs();
        t_brkpt();
        t_fault();
        t_stall();
        t_prio();
        t_reinit();
        print_verdict();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
endmodule // tb_sysbus_error_stall_priority
`default_nettype wire
